//--- hdl/lct_pkg.sv
// lct_pkg: register map, field positions and timing constants of the
// panel timing core; shared by the core and its bench.
package lct_pkg;
	localparam logic [31:0] LCT_CON1_ADDR = 32'h14a00000;
	localparam logic [31:0] LCT_CON2_ADDR = 32'h14a00004;
	localparam logic [31:0] LCT_CON3_ADDR = 32'h14a00008;
	localparam logic [31:0] LCT_CON4_ADDR = 32'h14a0000c;
	localparam logic [31:0] LCT_STAT_ADDR = 32'h14a00010;
	localparam logic [31:0] LCT_FILL_ADDR = 32'h14a00050;
	localparam logic [31:0] LCT_REG_RESET = 32'h00000000;
	// panel_control_first
	localparam int LCT_LCNT_POS  = 18;
	localparam int LCT_DIV_POS   = 8;
	localparam int LCT_ACSEL_BIT = 7;
	localparam int LCT_PTYPE_POS = 5;
	localparam int LCT_DEPTH_POS = 1;
	localparam int LCT_EN_BIT    = 0;
	// vertical_timing_control
	localparam int LCT_VBP_POS   = 24;
	localparam int LCT_VSIZE_POS = 14;
	localparam int LCT_VFP_POS   = 6;
	localparam int LCT_VSW_POS   = 0;
	// horizontal_timing_control
	localparam int LCT_HBP_POS   = 19;
	localparam int LCT_HSIZE_POS = 8;
	localparam int LCT_HFP_POS   = 0;
	// offset / bias rate / line pulse width register
	localparam int LCT_PALEN_BIT  = 24;
	localparam int LCT_PALOFS_POS = 16;
	localparam int LCT_ACRATE_POS = 8;
	localparam int LCT_HSW_POS    = 0;
	// status and fill registers
	localparam int LCT_VST_POS    = 19;
	localparam int LCT_HST_POS    = 17;
	localparam int LCT_FILLEN_BIT = 24;
	localparam int LCT_FILLV_POS  = 0;
	// codes and counts
	localparam logic [1:0]  LCT_PT_TFT     = 2'h3;
	localparam logic [3:0]  LCT_DEPTH_12   = 4'h4;
	localparam logic [9:0]  LCT_STN_DIVMIN = 10'h002;
	localparam logic [9:0]  LCT_TFT_DIVMIN = 10'h001;
	localparam logic [11:0] LCT_DLY_BASE   = 12'h010;
	localparam logic [1:0]  LCT_ST_SYNC    = 2'h0;
	localparam logic [1:0]  LCT_ST_BACK    = 2'h1;
	localparam logic [1:0]  LCT_ST_ACTIVE  = 2'h2;
	localparam logic [1:0]  LCT_ST_FRONT   = 2'h3;
	typedef enum logic [1:0] {LCT_SYNC, LCT_BACK, LCT_ACTIVE, LCT_FRONT} lct_phase_t;
endpackage : lct_pkg

//--- hdl/lct_panel_timing.sv
// lct_panel_timing: register file, pixel clock, line/frame timing and
// pixel colour path of the panel controller.
// assumes a fetch engine presenting fb_index and a palette returning
// pal_color; all inputs synchronous to sys_clk.
//
// How it works
// - fill enable replaces every pixel with fill
// - programmable offset added to palette index
// - line counter counts down from vertical size
// - pixel clock divided by divisor per mode
// - STN bias toggles per frame or every rate plus one lines
// - panel type field selects STN or TFT
// - pixel depth field selects bits per pixel
// - enable bit gates video and control signals
// - TFT back porch lines follow vertical sync
// - vertical size sets active lines
// - TFT front porch lines end each frame
// - TFT vertical sync width in lines, STN one line
// - TFT back porch in pixel clocks
// - STN line to clock delay 16..128
// - horizontal size sets active pixels
// - TFT front porch in pixel clocks
// - STN line blank in eight-clock units
// - vertical phase readable, 00 is sync
`timescale 1ns/1ns
module lct_panel_timing
	import lct_pkg::*;
(
	input  wire logic        sys_clk,
	input  wire logic        rst,
	input  wire logic [31:0] addr,
	input  wire logic [31:0] wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic      [31:0] rdata,
	input  wire logic [7:0]  fb_index,
	input  wire logic [15:0] pal_color,
	output logic      [7:0]  pal_index,
	output logic      [15:0] video_data,
	output logic             pixel_clock,
	output logic             line_pulse,
	output logic             frame_sync,
	output logic             data_enable,
	output logic             ac_bias_signal
);
	logic [17:0] con1;
	logic [31:0] con2;
	logic [25:0] con3;
	logic [24:0] con4;
	logic [24:0] fill;
	lct_phase_t  hph;
	lct_phase_t  vph;
	lct_phase_t  next_hph;
	lct_phase_t  next_vph;
	logic [11:0] hcnt;
	logic [10:0] vcnt;
	logic [11:0] hlen;
	logic [10:0] vlen;
	logic [10:0] dcnt;
	logic [10:0] half;
	logic [9:0]  div;
	logic [9:0]  line_cnt;
	logic [7:0]  accnt;
	logic [7:0]  mask;
	logic [1:0]  vstat;
	logic [1:0]  hstat;
	logic        enable;
	logic        tft;
	logic        pix_tick;
	logic        hstep;
	logic        hdone;
	logic        vdone;
	logic        line_end;
	logic        frame_end;
	logic        act;

	assign enable = con1[LCT_EN_BIT];
	assign tft    = con1[LCT_PTYPE_POS +: 2] == LCT_PT_TFT;
	assign div    = con1[LCT_DIV_POS +: 10];

	// register writes
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			con1 <= LCT_REG_RESET[17:0];
			con2 <= LCT_REG_RESET;
			con3 <= LCT_REG_RESET[25:0];
			con4 <= LCT_REG_RESET[24:0];
			fill <= LCT_REG_RESET[24:0];
		end else if (wr) begin
			unique case (addr)
				LCT_CON1_ADDR: con1 <= wdata[17:0];
				LCT_CON2_ADDR: con2 <= wdata;
				LCT_CON3_ADDR: con3 <= wdata[25:0];
				LCT_CON4_ADDR: con4 <= wdata[24:0];
				LCT_FILL_ADDR: fill <= wdata[24:0];
				default: ;
			endcase
		end
	end

	// register reads, data in the following cycle
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			rdata <= LCT_REG_RESET;
		end else if (rd) begin
			unique case (addr)
				LCT_CON1_ADDR: rdata <= {4'h0, line_cnt, con1};
				LCT_CON2_ADDR: rdata <= con2;
				LCT_CON3_ADDR: rdata <= {6'h00, con3};
				LCT_CON4_ADDR: rdata <= {7'h00, con4};
				LCT_STAT_ADDR: rdata <= {11'h000, vstat, hstat, 17'h00000};
				LCT_FILL_ADDR: rdata <= {7'h00, fill};
				default:       rdata <= LCT_REG_RESET;
			endcase
		end else begin
			rdata <= LCT_REG_RESET;
		end
	end

	// half period with per-mode minimum divisor
	always_comb begin
		if (tft) begin
			half = {1'b0, (div < LCT_TFT_DIVMIN) ? LCT_TFT_DIVMIN : div} + 11'h001;
		end else begin
			half = {1'b0, (div < LCT_STN_DIVMIN) ? LCT_STN_DIVMIN : div};
		end
	end

	assign pix_tick = enable && !pixel_clock && (dcnt == half - 11'h001);

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			dcnt        <= 11'h000;
			pixel_clock <= 1'b0;
		end else if (!enable) begin
			dcnt        <= 11'h000;
			pixel_clock <= 1'b0;
		end else if (dcnt >= half - 11'h001) begin
			dcnt        <= 11'h000;
			pixel_clock <= !pixel_clock;
		end else begin
			dcnt <= dcnt + 11'h001;
		end
	end

	// horizontal phase lengths
	always_comb begin
		unique case (hph)
			LCT_BACK: hlen = tft ? {5'h00, con3[LCT_HBP_POS +: 7]} + 12'h001
					: LCT_DLY_BASE << con3[LCT_HBP_POS +: 2];
			LCT_ACTIVE: hlen = {1'b0, con3[LCT_HSIZE_POS +: 11]} + 12'h001;
			LCT_FRONT: hlen = tft ? {4'h0, con3[LCT_HFP_POS +: 8]} + 12'h001
					: {1'b0, con3[LCT_HFP_POS +: 8], 3'h0};
			default: hlen = tft ? {4'h0, con4[LCT_HSW_POS +: 8]} + 12'h001
					: LCT_DLY_BASE << con4[LCT_HSW_POS +: 2];
		endcase
	end

	// vertical phase lengths
	always_comb begin
		unique case (vph)
			LCT_BACK: vlen = {3'h0, con2[LCT_VBP_POS +: 8]} + 11'h001;
			LCT_ACTIVE: vlen = {1'b0, con2[LCT_VSIZE_POS +: 10]} + 11'h001;
			LCT_FRONT: vlen = {3'h0, con2[LCT_VFP_POS +: 8]} + 11'h001;
			default: vlen = tft ? {5'h00, con2[LCT_VSW_POS +: 6]} + 11'h001 : 11'h001;
		endcase
	end

	assign hstep     = (tft || hph == LCT_ACTIVE) ? pix_tick : enable;
	assign hdone     = ({1'b0, hcnt} + 13'h0001) >= {1'b0, hlen};
	assign vdone     = ({1'b0, vcnt} + 12'h001) >= {1'b0, vlen};
	assign line_end  = hstep && hdone && hph == LCT_FRONT;
	assign frame_end = line_end && vdone && next_vph == LCT_SYNC;
	assign act       = enable && hph == LCT_ACTIVE && vph == LCT_ACTIVE;

	// phase order, STN skips vertical porches
	always_comb begin
		unique case (hph)
			LCT_SYNC:   next_hph = LCT_BACK;
			LCT_BACK:   next_hph = LCT_ACTIVE;
			LCT_ACTIVE: next_hph = LCT_FRONT;
			LCT_FRONT:  next_hph = LCT_SYNC;
		endcase
		unique case (vph)
			LCT_SYNC:   next_vph = tft ? LCT_BACK : LCT_ACTIVE;
			LCT_BACK:   next_vph = LCT_ACTIVE;
			LCT_ACTIVE: next_vph = tft ? LCT_FRONT : LCT_SYNC;
			LCT_FRONT:  next_vph = LCT_SYNC;
		endcase
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			hph  <= LCT_SYNC;
			hcnt <= 12'h000;
		end else if (!enable) begin
			hph  <= LCT_SYNC;
			hcnt <= 12'h000;
		end else if (hstep) begin
			if (hdone) begin
				hph  <= next_hph;
				hcnt <= 12'h000;
			end else begin
				hcnt <= hcnt + 12'h001;
			end
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			vph  <= LCT_SYNC;
			vcnt <= 11'h000;
		end else if (!enable) begin
			vph  <= LCT_SYNC;
			vcnt <= 11'h000;
		end else if (line_end) begin
			if (vdone) begin
				vph  <= next_vph;
				vcnt <= 11'h000;
			end else begin
				vcnt <= vcnt + 11'h001;
			end
		end
	end

	assign line_cnt = (vph == LCT_ACTIVE) ? con2[LCT_VSIZE_POS +: 10] - vcnt[9:0] : 10'h000;

	always_comb begin
		unique case (vph)
			LCT_SYNC:   vstat = LCT_ST_SYNC;
			LCT_BACK:   vstat = LCT_ST_BACK;
			LCT_ACTIVE: vstat = LCT_ST_ACTIVE;
			LCT_FRONT:  vstat = LCT_ST_FRONT;
		endcase
		unique case (hph)
			LCT_SYNC:   hstat = LCT_ST_SYNC;
			LCT_BACK:   hstat = LCT_ST_BACK;
			LCT_ACTIVE: hstat = LCT_ST_ACTIVE;
			LCT_FRONT:  hstat = LCT_ST_FRONT;
		endcase
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			line_pulse  <= 1'b0;
			frame_sync  <= 1'b0;
			data_enable <= 1'b0;
		end else begin
			line_pulse  <= enable && hph == LCT_SYNC;
			frame_sync  <= enable && vph == LCT_SYNC;
			data_enable <= act;
		end
	end

	// STN bias toggle per frame or every rate plus one lines
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ac_bias_signal <= 1'b0;
			accnt          <= 8'h00;
		end else if (!enable || tft) begin
			ac_bias_signal <= 1'b0;
			accnt          <= 8'h00;
		end else if (!con1[LCT_ACSEL_BIT]) begin
			if (frame_end) begin
				ac_bias_signal <= !ac_bias_signal;
			end
		end else if (line_end) begin
			if (accnt >= con4[LCT_ACRATE_POS +: 8]) begin
				ac_bias_signal <= !ac_bias_signal;
				accnt          <= 8'h00;
			end else begin
				accnt <= accnt + 8'h01;
			end
		end
	end

	always_comb begin
		unique case (con1[LCT_DEPTH_POS +: 2])
			2'h0: mask = 8'h01;
			2'h1: mask = 8'h03;
			2'h2: mask = 8'h0f;
			2'h3: mask = 8'hff;
		endcase
		if (con1[LCT_DEPTH_POS +: 4] == LCT_DEPTH_12) begin
			mask = 8'hff;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			pal_index  <= 8'h00;
			video_data <= 16'h0000;
		end else if (!act) begin
			video_data <= 16'h0000;
		end else if (pix_tick) begin
			pal_index  <= (fb_index & mask)
					+ (con4[LCT_PALEN_BIT] ? con4[LCT_PALOFS_POS +: 8] : 8'h00);
			video_data <= fill[LCT_FILLEN_BIT] ? fill[LCT_FILLV_POS +: 16] : pal_color;
		end
	end

	dis_quiet_a: assert property (@(posedge sys_clk) disable iff (rst)
		!enable |=> !line_pulse && !frame_sync && !data_enable && !pixel_clock)
		else $error("outputs active while disabled");
	idle_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
		!enable |=> hph == LCT_SYNC && vph == LCT_SYNC && hcnt == 12'h000 && vcnt == 11'h000)
		else $error("timing not idle while disabled");
	fill_wins_a: assert property (@(posedge sys_clk) disable iff (rst)
		act && pix_tick && fill[LCT_FILLEN_BIT] |=> video_data == $past(fill[15:0]))
		else $error("fill colour not shown");
	pal_offset_a: assert property (@(posedge sys_clk) disable iff (rst)
		act && pix_tick && con4[LCT_PALEN_BIT] && con1[4:1] == 4'hb
		|=> pal_index == 8'($past(fb_index) + $past(con4[23:16])))
		else $error("palette offset wrong");
	clk_half_a: assert property (@(posedge sys_clk) disable iff (rst)
		enable && half == 11'h002 && $rose(pixel_clock) |-> pixel_clock ##2 $fell(pixel_clock))
		else $error("pixel clock half period wrong");
	line_cnt_a: assert property (@(posedge sys_clk) disable iff (rst)
		vph == LCT_ACTIVE && vcnt == 11'h000 |-> line_cnt == con2[23:14])
		else $error("line counter not at vertical size");
	vstat_sync_a: assert property (@(posedge sys_clk) disable iff (rst)
		enable && vph == LCT_SYNC |=> frame_sync == (vstat == LCT_ST_SYNC) || $changed(vph))
		else $error("sync status mismatch");
	phase_order_a: assert property (@(posedge sys_clk) disable iff (rst)
		tft && enable && $changed(vph) && vph == LCT_ACTIVE |-> $past(vph) == LCT_BACK)
		else $error("active lines not after back porch");
	ac_frame_a: assert property (@(posedge sys_clk) disable iff (rst)
		enable && !tft && !con1[7] && frame_end |=> ac_bias_signal != $past(ac_bias_signal))
		else $error("bias did not toggle at frame end");
	stat_sync_a: assert property (@(posedge sys_clk) disable iff (rst)
		rd && addr == LCT_STAT_ADDR && vph == LCT_SYNC |=> rdata[20:19] == 2'h0)
		else $error("sync phase not reported as zero");
	lcnt_zero_a: assert property (@(posedge sys_clk) disable iff (rst)
		vph == LCT_ACTIVE && vcnt[9:0] == con2[23:14] |-> line_cnt == 10'h000)
		else $error("line counter not zero on last line");
	back_lines_a: assert property (@(posedge sys_clk) disable iff (rst)
		enable && tft && vph == LCT_BACK |-> vcnt <= {3'h0, con2[31:24]})
		else $error("back porch too long");
	active_lines_a: assert property (@(posedge sys_clk) disable iff (rst)
		enable && vph == LCT_ACTIVE |-> vcnt <= {1'b0, con2[23:14]})
		else $error("too many active lines");
	front_lines_a: assert property (@(posedge sys_clk) disable iff (rst)
		enable && tft && vph == LCT_FRONT |-> vcnt <= {3'h0, con2[13:6]})
		else $error("front porch too long");
	sync_lines_a: assert property (@(posedge sys_clk) disable iff (rst)
		enable && tft && vph == LCT_SYNC |-> vcnt <= {5'h00, con2[5:0]})
		else $error("vertical sync too long");
	active_pixels_a: assert property (@(posedge sys_clk) disable iff (rst)
		enable && hph == LCT_ACTIVE |-> hcnt <= {1'b0, con3[18:8]})
		else $error("too many active pixels");
endmodule : lct_panel_timing

//--- verif/lct_panel_model.sv
// lct_panel_model: behavioural panel monitor on the link side of the core.
// assumes the link outputs are registered to sys_clk; it only listens.
`timescale 1ns/1ns
module lct_panel_model (
	input  wire logic        sys_clk,
	input  wire logic        rst,
	input  wire logic        pixel_clock,
	input  wire logic        line_pulse,
	input  wire logic        frame_sync,
	input  wire logic        data_enable,
	input  wire logic        ac_bias_signal,
	input  wire logic [15:0] video_data,
	output int               frame_cnt,
	output int               pclk_period,
	output int               frame_lines,
	output int               act_clks,
	output int               bias_tgl,
	output int               sync_clks,
	output logic      [15:0] last_px
);
	logic pc_q, lp_q, fs_q, ab_q;
	int   per, lines, act, tgl, syn;
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			{pc_q, lp_q, fs_q, ab_q} <= 4'h0;
			{per, lines, act, tgl, syn} <= '0;
			{frame_cnt, pclk_period, frame_lines, act_clks, bias_tgl, sync_clks} <= '0;
			last_px <= 16'h0000;
		end else begin
			pc_q <= pixel_clock;
			lp_q <= line_pulse;
			fs_q <= frame_sync;
			ab_q <= ac_bias_signal;
			per  <= (pixel_clock && !pc_q) ? 1 : per + 1;
			if (pixel_clock && !pc_q)
				pclk_period <= per;
			if (data_enable)
				last_px <= video_data;
			if (frame_sync && !fs_q) begin
				frame_cnt   <= frame_cnt + 1;
				frame_lines <= lines;
				act_clks    <= act;
				bias_tgl    <= tgl;
				sync_clks   <= syn;
				lines <= int'(line_pulse && !lp_q);
				act   <= int'(data_enable);
				tgl   <= int'(ac_bias_signal != ab_q);
				syn   <= 1;
			end else begin
				lines <= lines + int'(line_pulse && !lp_q);
				act   <= act + int'(data_enable);
				tgl   <= tgl + int'(ac_bias_signal != ab_q);
				syn   <= syn + int'(frame_sync);
			end
		end
	end
endmodule : lct_panel_model

//--- verif/tb_top.sv
// tb_top: register-level tests of the panel timing core with a panel model.
// assumes a 100 MHz sys_clk and a constant fetch index; the palette colour is changed once.
`timescale 1ns/1ns
module tb_top import lct_pkg::*;;
	logic        sys_clk, rst, wr, rd;
	logic [31:0] addr, wdata, rdata, d;
	logic [7:0]  fb_index, pal_index;
	logic [15:0] pal_color, video_data, last_px;
	logic        pixel_clock, line_pulse, frame_sync, data_enable, ac_bias_signal;
	logic        top, over;
	logic [3:0]  seen;
	int          frame_cnt, pclk_period, frame_lines, act_clks, bias_tgl, sync_clks;
	int          err_count, check_count;
	logic [31:0] m_con1 [3] = '{32'h00000347, 32'h000003c7, 32'h00000177};
	logic [31:0] m_con2 [3] = '{32'h00004000, 32'h00004000, 32'h01004001};
	int          m_per  [3] = '{6, 6, 4};
	int          m_lin  [3] = '{3, 3, 7};
	int          m_act  [3] = '{40, 40, 32};
	int          m_tgl  [3] = '{1, 3, 0};
	int          m_syn  [3] = '{108, 108, 80};
	logic [7:0]  m_idx  [4] = '{8'h01, 8'h01, 8'h05, 8'h35};

	lct_panel_timing uut (.sys_clk(sys_clk), .rst(rst), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .fb_index(fb_index), .pal_color(pal_color),
		.pal_index(pal_index), .video_data(video_data), .pixel_clock(pixel_clock),
		.line_pulse(line_pulse), .frame_sync(frame_sync), .data_enable(data_enable),
		.ac_bias_signal(ac_bias_signal));
	lct_panel_model panel (.sys_clk(sys_clk), .rst(rst), .pixel_clock(pixel_clock),
		.line_pulse(line_pulse), .frame_sync(frame_sync), .data_enable(data_enable),
		.ac_bias_signal(ac_bias_signal), .video_data(video_data), .frame_cnt(frame_cnt),
		.pclk_period(pclk_period), .frame_lines(frame_lines), .act_clks(act_clks),
		.bias_tgl(bias_tgl), .sync_clks(sync_clks), .last_px(last_px));

	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR at %0t: %s got %h exp %h", $time, what, got, exp);
		end
	endtask : chk

	task wr_reg(input logic [31:0] a, input logic [31:0] v);
		@(posedge sys_clk);
		wr    <= 1'b1;
		addr  <= a;
		wdata <= v;
		@(posedge sys_clk);
		wr <= 1'b0;
	endtask : wr_reg

	task rd_reg(input logic [31:0] a, output logic [31:0] v);
		@(posedge sys_clk);
		rd   <= 1'b1;
		addr <= a;
		@(posedge sys_clk);
		rd <= 1'b0;
		#1 v = rdata;
	endtask : rd_reg

	task wait_frames(input int n);
		int start;
		start = frame_cnt;
		for (int i = 0; i < 5000 && frame_cnt < start + n; i++)
			@(posedge sys_clk);
		chk(32'(frame_cnt >= start + n), 32'h1, "frame wait");
	endtask : wait_frames

	task test_done();
		$display("errors %0d checks %0d", err_count, check_count);
		if (err_count == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : test_done

	initial begin
		#300000;
		err_count++;
		test_done();
	end

	initial begin
		{rst, wr, rd, addr, wdata} = {1'b1, 66'h0};
		fb_index  = 8'h35;
		pal_color = 16'h1234;
		repeat (4) @(posedge sys_clk);
		rst <= 1'b0;
		foreach (m_con1[i]) begin
			rd_reg(LCT_CON1_ADDR + 32'(4 * i), d);
			chk(d, LCT_REG_RESET, "reset value");
		end
		wr_reg(LCT_CON1_ADDR, 32'hfffffffe);
		rd_reg(LCT_CON1_ADDR, d);
		chk(d, 32'h0003fffe, "line counter read only");
		wr_reg(LCT_CON2_ADDR, 32'hffffffff);
		rd_reg(LCT_CON2_ADDR, d);
		chk(d, 32'hffffffff, "vertical fields");
		wr_reg(32'h14a00020, 32'hffffffff);
		rd_reg(32'h14a00020, d);
		chk(d, 32'h0, "unmapped read");
		wr_reg(LCT_CON3_ADDR, 32'h00100301); // line geometry set once
		wr_reg(LCT_CON4_ADDR, 32'h0);
		for (int m = 0; m < 3; m++) begin
			wr_reg(LCT_CON1_ADDR, 32'h0);
			repeat (3) @(posedge sys_clk);
			chk({pixel_clock, line_pulse, frame_sync, data_enable, ac_bias_signal, video_data},
				32'h0, "outputs off");
			wr_reg(LCT_CON2_ADDR, m_con2[m]);
			wr_reg(LCT_CON1_ADDR, m_con1[m]);
			rd_reg(LCT_STAT_ADDR, d);
			chk(d[20:19], LCT_ST_SYNC, "restart at sync");
			wait_frames(3);
			chk(pclk_period, m_per[m], "pixel clock period");
			chk(frame_lines, m_lin[m], "lines per frame");
			chk(act_clks, m_act[m], "active clocks");
			chk(bias_tgl, m_tgl[m], "bias toggles");
			chk(sync_clks, m_syn[m], "sync length");
		end
		{top, over, seen} = 6'h0;
		for (int i = 0; i < 150; i++) begin
			rd_reg(LCT_CON1_ADDR, d);
			top  = top | (d[27:18] == 10'h001);
			over = over | (d[27:18] > 10'h001);
			rd_reg(LCT_STAT_ADDR, d);
			seen[d[20:19]] = 1'b1;
		end
		chk(top, 1'b1, "line counter top");
		chk(over, 1'b0, "line counter range");
		chk(seen, 4'hf, "all vertical phases");
		chk(last_px, 16'h1234, "palette colour");
		// palette changed only outside active lines
		d = 32'h0;
		for (int i = 0; i < 200 && d[20:19] != LCT_ST_FRONT; i++)
			rd_reg(LCT_STAT_ADDR, d);
		chk(d[20:19], LCT_ST_FRONT, "palette window");
		@(posedge sys_clk);
		pal_color <= 16'h5678;
		for (int k = 0; k < 4; k++) begin
			wr_reg(LCT_CON1_ADDR, 32'h00000171 | 32'(k << 1));
			wait_frames(2);
			chk(pal_index, m_idx[k], "depth mask");
		end
		chk(last_px, 16'h5678, "palette rewritten");
		wr_reg(LCT_CON4_ADDR, 32'h01100000);
		wait_frames(2);
		chk(pal_index, 8'h45, "index offset");
		wr_reg(LCT_FILL_ADDR, 32'h0100abcd);
		wait_frames(2);
		chk(last_px, 16'habcd, "fill colour");
		rd_reg(LCT_CON3_ADDR, d);
		chk(d, 32'h00100301, "line geometry kept");
		test_done();
	end
endmodule : tb_top
